// ### dv/i2c_slave_register_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "isp_params.svh"

module i2c_slave_register_port_tb_top;
	import isp_pkg::*;
	logic        core_clk;
	logic        link_clk;
	logic        arst_n;
	logic        cmd_valid;
	isp_op_t     cmd_op;
	logic [6:0]  cmd_dev;
	logic [7:0]  cmd_reg;
	logic [7:0]  cmd_data;
	logic        cmd_ready;
	logic        rsp_valid;
	logic        rsp_nack;
	logic        regs_upd_o;
	logic [7:0]  rsp_data;
	logic [7:0]  rnd;
	logic [7:0]  ptr;
	isp_regs_t   regs_o;
	isp_regs_t   shadow;
	logic [7:0]  n_wr;
	logic [7:0]  n_upd;
	logic [49:0] note;
	logic [49:0] notes[$];
	int          n_errors;
	int          total_checks;

	isp_if bus_if ();
	isp_dev isp_dev_i (.link_clk(link_clk), .bus(bus_if), .core_clk(core_clk),
		.arst_n(arst_n), .regs_o(regs_o), .regs_upd_o(regs_upd_o));
	isp_hst isp_hst_i (.core_clk(core_clk), .arst_n(arst_n), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack));
	isp_monitor isp_monitor_i (.link_clk(link_clk), .arst_n(arst_n),
		.host_scl_oe(bus_if.host_scl_oe), .host_sda_oe(bus_if.host_sda_oe),
		.dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Drive one command and note the answer it should bring
	task automatic run(input isp_op_t op, input logic [6:0] dev, input logic [7:0] rg,
		input logic [7:0] dat);
		logic       own;
		logic [7:0] exp;
		own = (dev == `ISP_SLV_ADDR);
		if (own && op != OP_RD) ptr = rg;
		if (own && op == OP_WR && rg < `ISP_NREG) begin
			shadow[rg[1:0]] = dat;
			n_wr = n_wr + 8'h01;
		end
		exp = (ptr < `ISP_NREG) ? shadow[ptr[1:0]] : 8'h00;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_dev <= dev;
		cmd_reg <= rg;
		cmd_data <= dat;
		notes.push_back({n_wr, op[1] & own, ~own, exp, shadow});
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		do begin
			@(posedge core_clk);
			#1;
		end while (cmd_ready !== 1'b1);
		$display("op %0d to %h done", op, dev);
	endtask

	always @(posedge core_clk) begin
		if (rsp_valid === 1'b1) begin
			note = notes.pop_front();
			check("rsp_nack", note[40], rsp_nack);
			if (note[41]) check("rsp_data", note[39:32], rsp_data);
			check("regs_o", note[31:0], regs_o);
			check("regs_upd_o", note[49:42], n_upd);
		end
	end

	// Count update pulses of the user-side register copy
	always @(posedge core_clk) begin
		if (!arst_n) begin
			n_upd <= 8'h00;
		end else if (regs_upd_o === 1'b1) begin
			n_upd <= n_upd + 8'h01;
		end
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		n_errors++;
		report_and_stop();
	end

	initial begin
		arst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_WR;
		cmd_dev = 7'h00;
		cmd_reg = 8'h00;
		cmd_data = 8'h00;
		rnd = 8'h03;
		ptr = 8'h00;
		n_wr = 8'h00;
		shadow = {8'h00, 8'h10, 8'h00, 8'h00};
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		check("regs_o", shadow, regs_o);
		repeat (8) @(posedge core_clk);
		rnd = lfsr(rnd);
		run(OP_WR, 7'h37, 8'h01, rnd);
		rnd = lfsr(rnd);
		run(OP_WR, 7'h37, 8'h03, rnd);
		run(OP_CMB, 7'h37, 8'h01, 8'h00);
		run(OP_CMB, 7'h37, 8'h02, 8'h00);
		rnd = lfsr(rnd);
		run(OP_WR, 7'h37, 8'h05, rnd);
		run(OP_CMB, 7'h37, 8'h05, 8'h00);
		run(OP_PTR, 7'h37, 8'h03, 8'h00);
		rnd = lfsr(rnd);
		run(OP_WR, {5'h1e, rnd[1:0]}, 8'h01, rnd);
		run(OP_RD, 7'h37, 8'h00, 8'h00);
		run(OP_RD, 7'h37, 8'h00, 8'h00);
		rnd = lfsr(rnd);
		run(OP_RD, 7'h37 ^ {rnd[6:1], 1'b1}, 8'h00, 8'h00);
		run(OP_RD, 7'h37, 8'h00, 8'h00);
		// Let the last response reach the checker before the verdict
		repeat (4) @(posedge core_clk);
		check("notes_left", 32'h0, notes.size());
		report_and_stop();
	end
endmodule

`default_nettype wire

// ### dv/isp_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module isp_monitor (
	// Clock and reset
	input wire logic link_clk,
	input wire logic arst_n,
	// Bus
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       rise;
	logic       start;
	logic       ack9;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] addr_q;
	logic [1:0] byte_q;

	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign ack9  = rise & (cnt_q == 4'h8);

	// Bit and byte position inside the current frame
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			addr_q <= 8'h00;
			byte_q <= 2'h0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				cnt_q  <= 4'h0;
				byte_q <= 2'h0;
			end else if (rise) begin
				cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
				if (cnt_q != 4'h8)
					sh_q <= {sh_q[6:0], sda};
				else if (byte_q != 2'h3)
					byte_q <= byte_q + 2'h1;
				if (cnt_q == 4'h8 && byte_q == 2'h0)
					addr_q <= sh_q;
			end
		end
	end

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!arst_n);

	a_own_addr_ack:
	assert property (ack9 && byte_q == 2'h0 && sh_q[7:1] == 7'h37 |-> dev_sda_oe)
		else $error("own address not acked");
	a_ack_latency:
	assert property ($fell(scl) && cnt_q == 4'h8 && byte_q == 2'h0 && sh_q[7:1] == 7'h37
		|-> ##[1:8] dev_sda_oe) else $error("address ack late");
	a_reg_byte_ack:
	assert property (ack9 && byte_q == 2'h1 && addr_q == 8'h6e |-> dev_sda_oe)
		else $error("register byte not acked");
	a_data_byte_ack:
	assert property (ack9 && byte_q == 2'h2 && addr_q == 8'h6e |-> dev_sda_oe)
		else $error("data byte not acked");
	a_read_ack_free:
	assert property (ack9 && byte_q == 2'h1 && addr_q == 8'h6f |-> !dev_sda_oe)
		else $error("device drove master ack slot");
	a_ignore_foreign:
	assert property (byte_q != 2'h0 && addr_q[7:1] != 7'h37 |-> !dev_sda_oe)
		else $error("device drove foreign frame");
	a_addr_not_driven:
	assert property (byte_q == 2'h0 && cnt_q != 4'h8 |-> !dev_sda_oe)
		else $error("device drove address bits");
	a_hold_scl_high:
	assert property (scl && $past(scl, 8) |-> $stable(dev_sda_oe))
		else $error("device sda changed while scl high");
	a_host_yields_sda:
	assert property (!host_scl_oe && dev_sda_oe |-> !host_sda_oe)
		else $error("host drove sda against device");
endmodule

`default_nettype wire

// ### pkg/isp_if.sv
`timescale 1ns/1ns
`default_nettype none

interface isp_if;
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired AND with pull-up
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport dev  (input scl, input sda, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface

`default_nettype wire

// ### pkg/isp_params.svh
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH

// Bus address and direction
`define ISP_SLV_ADDR     7'h37
`define ISP_DIR_WR       1'b0
`define ISP_DIR_RD       1'b1

// Register file
`define ISP_NREG         8'h04
`define ISP_RST_R0       8'h00
`define ISP_RST_R1       8'h00
`define ISP_RST_R2       8'h10
`define ISP_RST_R3       8'h00

// Byte framing
`define ISP_LAST_BIT     3'h7
`define ISP_ACK_SLOT     4'h8

// Timing: fast mode bit period, quarter period rounded up to whole cycles
`define ISP_CORE_PERIOD_NS 10
`define ISP_SCL_PERIOD_NS  2500
`define ISP_QTR_CYC \
	(((`ISP_SCL_PERIOD_NS / 4) + `ISP_CORE_PERIOD_NS - 1) / `ISP_CORE_PERIOD_NS)

`endif

// ### pkg/isp_pkg.sv
package isp_pkg;

	typedef logic [3:0][7:0] isp_regs_t;

	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_ADDR = 3'b001,
		DS_REG  = 3'b010,
		DS_DATA = 3'b011,
		DS_ACK  = 3'b100,
		DS_TX   = 3'b101,
		DS_MACK = 3'b110
	} isp_dst_t;

	typedef enum logic [1:0] {
		OP_WR  = 2'b00,
		OP_PTR = 2'b01,
		OP_CMB = 2'b10,
		OP_RD  = 2'b11
	} isp_op_t;

	typedef enum logic [1:0] {
		EL_S = 2'b00,
		EL_B = 2'b01,
		EL_P = 2'b10
	} isp_el_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_RUN  = 2'b01,
		HS_DONE = 2'b10
	} isp_hst_t;

endpackage

// ### rtl/isp_dev.sv
// Operation
// - Decode 7-bit addresses only, nothing else.
// - Work at standard and fast rates.
// - Match address 0110111, bytes 0x6E/0x6F.
// - Address byte bit zero selects direction.
// - Write: address, register, data, each acknowledged.
// - Combined read: restart, read address, data.
// - Master ends read with NACK, stop.
// - Pointer survives transfer end for later reads.
// - Foreign traffic ignored, pointer kept.
// - Deferred read after start or restart.
// - Slave drives all address/register/data acknowledges.
// - No pointer auto-increment or auto-decrement.
// - Four user registers, eight bits each.
`timescale 1ns/1ns
`default_nettype none
`include "isp_params.svh"

module isp_dev (
	// Link side
	input  wire logic           link_clk,
	isp_if.dev                  bus,
	// User side
	input  wire logic           core_clk,
	input  wire logic           arst_n,
	output var  isp_pkg::isp_regs_t regs_o,
	output var  logic           regs_upd_o
);
	import isp_pkg::*;

	localparam isp_regs_t RST_REGS =
		{`ISP_RST_R3, `ISP_RST_R2, `ISP_RST_R1, `ISP_RST_R0};

	// Link domain state
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic       scl_f;
		logic       sda_f;
		isp_dst_t   st;
		isp_dst_t   ack_nx;
		logic       ph;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		isp_regs_t  regs;
		logic       sda_oe;
		logic       upd_t;
	} isp_lnk_t;

	// Core domain state
	typedef struct packed {
		logic [2:0] tg_s;
		logic       tg_acc;
		isp_regs_t  regs;
		logic       upd;
	} isp_cor_t;

	localparam isp_lnk_t L_RST = '{
		scl_s:  3'h7,
		sda_s:  3'h7,
		scl_f:  1'b1,
		sda_f:  1'b1,
		st:     DS_IDLE,
		ack_nx: DS_IDLE,
		ph:     1'b0,
		cnt:    3'h0,
		sh:     8'h00,
		ptr:    8'h00,
		regs:   RST_REGS,
		sda_oe: 1'b0,
		upd_t:  1'b0
	};

	localparam isp_cor_t C_RST = '{
		tg_s:   3'h0,
		tg_acc: 1'b0,
		regs:   RST_REGS,
		upd:    1'b0
	};

	isp_lnk_t l_q;
	isp_lnk_t l_d;
	isp_cor_t c_q;
	isp_cor_t c_d;

	assign bus.dev_sda_oe = l_q.sda_oe;
	assign regs_o         = c_q.regs;
	assign regs_upd_o     = c_q.upd;

	always_comb begin
		logic       scl_nf;
		logic       sda_nf;
		logic       rise;
		logic       fall;
		logic       start;
		logic       stop;
		logic [7:0] byte_in;
		logic [7:0] rd_byte;
		scl_nf  = l_q.scl_f;
		sda_nf  = l_q.sda_f;
		rise    = 1'b0;
		fall    = 1'b0;
		start   = 1'b0;
		stop    = 1'b0;
		byte_in = 8'h00;
		rd_byte = 8'h00;
		l_d     = l_q;

		// Pins pass three flops; a level counts once the last two agree
		l_d.scl_s = {l_q.scl_s[1:0], bus.scl};
		l_d.sda_s = {l_q.sda_s[1:0], bus.sda};
		if (l_q.scl_s[1] == l_q.scl_s[2]) begin
			scl_nf = l_q.scl_s[2];
		end
		if (l_q.sda_s[1] == l_q.sda_s[2]) begin
			sda_nf = l_q.sda_s[2];
		end
		l_d.scl_f = scl_nf;
		l_d.sda_f = sda_nf;

		rise  = scl_nf & ~l_q.scl_f;
		fall  = ~scl_nf & l_q.scl_f;
		start = scl_nf & l_q.scl_f & l_q.sda_f & ~sda_nf;
		stop  = scl_nf & l_q.scl_f & ~l_q.sda_f & sda_nf;

		byte_in = {l_q.sh[6:0], sda_nf};
		if (l_q.ptr < `ISP_NREG) begin
			rd_byte = l_q.regs[l_q.ptr[1:0]];
		end else begin
			rd_byte = 8'h00;
		end

		if (stop) begin
			// Pointer is left as is across stops
			l_d.st     = DS_IDLE;
			l_d.sda_oe = 1'b0;
		end else if (start) begin
			// Start and repeated start both reopen address decode
			l_d.st     = DS_ADDR;
			l_d.cnt    = 3'h0;
			l_d.sda_oe = 1'b0;
		end else begin
			case (l_q.st)
				DS_ADDR, DS_REG, DS_DATA: begin
					if (rise) begin
						l_d.sh  = byte_in;
						l_d.cnt = l_q.cnt + 3'h1;
						if (l_q.cnt == `ISP_LAST_BIT) begin
							l_d.st = DS_ACK;
							l_d.ph = 1'b0;
							case (l_q.st)
								DS_ADDR: begin
									// Ten-bit and CBUS headers never match
									if (byte_in[7:1] == `ISP_SLV_ADDR) begin
										if (byte_in[0] == `ISP_DIR_RD) begin
											l_d.ack_nx = DS_TX;
										end else begin
											l_d.ack_nx = DS_REG;
										end
									end else begin
										l_d.st = DS_IDLE;
									end
								end
								DS_REG: begin
									l_d.ptr    = byte_in;
									l_d.ack_nx = DS_DATA;
								end
								default: begin
									if (l_q.ptr < `ISP_NREG) begin
										l_d.regs[l_q.ptr[1:0]] = byte_in;
										l_d.upd_t = ~l_q.upd_t;
									end
									// Pointer stays put after the data byte
									l_d.ack_nx = DS_IDLE;
								end
							endcase
						end
					end
				end
				DS_ACK: begin
					if (fall) begin
						if (!l_q.ph) begin
							l_d.ph     = 1'b1;
							l_d.sda_oe = 1'b1;
						end else begin
							l_d.st     = l_q.ack_nx;
							l_d.cnt    = 3'h0;
							l_d.sda_oe = 1'b0;
							if (l_q.ack_nx == DS_TX) begin
								l_d.sh     = rd_byte;
								l_d.sda_oe = ~rd_byte[7];
							end
						end
					end
				end
				DS_TX: begin
					if (rise) begin
						l_d.cnt = l_q.cnt + 3'h1;
						if (l_q.cnt == `ISP_LAST_BIT) begin
							l_d.st = DS_MACK;
						end
					end else if (fall) begin
						l_d.sh     = {l_q.sh[6:0], 1'b0};
						l_d.sda_oe = ~l_q.sh[6];
					end
				end
				DS_MACK: begin
					// Master answers the single byte; no second byte is sent
					if (fall) begin
						l_d.sda_oe = 1'b0;
					end else if (rise) begin
						l_d.st = DS_IDLE;
					end
				end
				DS_IDLE: begin
					l_d.sda_oe = 1'b0;
				end
				default: begin
					l_d.st     = DS_IDLE;
					l_d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			l_q <= L_RST;
		end else begin
			l_q <= l_d;
		end
	end

	// Write toggle crosses in three flops; the register word is stable
	// long before the toggle settles, so it is copied on acceptance
	always_comb begin
		c_d      = c_q;
		c_d.upd  = 1'b0;
		c_d.tg_s = {c_q.tg_s[1:0], l_q.upd_t};
		if ((c_q.tg_s[1] == c_q.tg_s[2]) && (c_q.tg_s[2] != c_q.tg_acc)) begin
			c_d.tg_acc = c_q.tg_s[2];
			c_d.regs   = l_q.regs;
			c_d.upd    = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			c_q <= C_RST;
		end else begin
			c_q <= c_d;
		end
	end

endmodule

`default_nettype wire

// ### rtl/isp_hst.sv
`timescale 1ns/1ns
`default_nettype none
`include "isp_params.svh"

module isp_hst (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	// Link side
	isp_if.host                   bus,
	// Command
	input  wire logic             cmd_valid,
	input  wire isp_pkg::isp_op_t cmd_op,
	input  wire logic [6:0]       cmd_dev,
	input  wire logic [7:0]       cmd_reg,
	input  wire logic [7:0]       cmd_data,
	output var  logic             cmd_ready,
	// Response
	output var  logic             rsp_valid,
	output var  logic [7:0]       rsp_data,
	output var  logic             rsp_nack
);
	import isp_pkg::*;

	localparam logic [6:0] QTR_LAST = 7'(`ISP_QTR_CYC - 1);

	typedef struct packed {
		logic [2:0] sda_s;
		logic       sda_f;
		isp_hst_t   st;
		isp_op_t    op;
		logic [6:0] dev;
		logic [7:0] regb;
		logic [7:0] datab;
		logic [2:0] step;
		isp_el_t    el;
		logic       rd;
		logic [1:0] q;
		logic [6:0] tcnt;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic       nack;
		logic       scl_oe;
		logic       sda_oe;
		logic       ready;
		logic       rsp;
	} isp_hq_t;

	isp_hq_t r_q;
	isp_hq_t r_d;

	assign bus.host_scl_oe = r_q.scl_oe;
	assign bus.host_sda_oe = r_q.sda_oe;
	assign cmd_ready       = r_q.ready;
	assign rsp_valid       = r_q.rsp;
	assign rsp_data        = r_q.sh;
	assign rsp_nack        = r_q.nack;

	// Frame element sequence for each operation
	function automatic isp_el_t el_of(input isp_op_t op, input logic [2:0] s);
		case (op)
			OP_WR:   el_of = (s == 3'h0) ? EL_S : (s == 3'h4) ? EL_P : EL_B;
			OP_PTR:  el_of = (s == 3'h0) ? EL_S : (s == 3'h3) ? EL_P : EL_B;
			OP_CMB:  el_of = (s == 3'h0 || s == 3'h3) ? EL_S :
				(s == 3'h6) ? EL_P : EL_B;
			default: el_of = (s == 3'h0) ? EL_S : (s == 3'h3) ? EL_P : EL_B;
		endcase
	endfunction

	function automatic logic rd_of(input isp_op_t op, input logic [2:0] s);
		rd_of = ((op == OP_RD) && (s == 3'h2)) || ((op == OP_CMB) && (s == 3'h5));
	endfunction

	always_comb begin
		logic tick;
		logic sda_v;
		logic scl_v;
		tick  = (r_q.tcnt == QTR_LAST);
		sda_v = 1'b1;
		scl_v = 1'b1;
		r_d   = r_q;
		r_d.rsp = 1'b0;

		r_d.sda_s = {r_q.sda_s[1:0], bus.sda};
		if (r_q.sda_s[1] == r_q.sda_s[2]) begin
			r_d.sda_f = r_q.sda_s[2];
		end

		case (r_q.st)
			HS_IDLE: begin
				if (cmd_valid && r_q.ready) begin
					r_d.ready = 1'b0;
					r_d.st    = HS_RUN;
					r_d.op    = cmd_op;
					r_d.dev   = cmd_dev;
					r_d.regb  = cmd_reg;
					r_d.datab = cmd_data;
					r_d.nack  = 1'b0;
					r_d.step  = 3'h0;
					r_d.el    = EL_S;
					r_d.q     = 2'h0;
					r_d.tcnt  = 7'h00;
				end
			end
			HS_RUN: begin
				r_d.tcnt = r_q.tcnt + 7'h01;
				if (tick) begin
					r_d.tcnt = 7'h00;
					r_d.q    = r_q.q + 2'h1;
					if (r_q.el == EL_B && r_q.q == 2'h2) begin
						if (r_q.bitn == `ISP_ACK_SLOT) begin
							if (!r_q.rd && r_q.sda_f) begin
								r_d.nack = 1'b1;
							end
						end else if (r_q.rd) begin
							r_d.sh = {r_q.sh[6:0], r_q.sda_f};
						end
					end
					if (r_q.q == 2'h3) begin
						if (r_q.el == EL_P) begin
							r_d.st = HS_DONE;
						end else if (r_q.el == EL_B && r_q.bitn != `ISP_ACK_SLOT) begin
							r_d.bitn = r_q.bitn + 4'h1;
							if (!r_q.rd) begin
								r_d.sh = {r_q.sh[6:0], 1'b0};
							end
						end else if (r_d.nack) begin
							r_d.el = EL_P;
						end else begin
							r_d.step = r_q.step + 3'h1;
							r_d.el   = el_of(r_q.op, r_d.step);
							r_d.rd   = rd_of(r_q.op, r_d.step);
							r_d.bitn = 4'h0;
							// Read bytes and the stop keep the shifted-in byte for rsp_data
							if (r_d.el == EL_B && !r_d.rd) begin
								case (r_d.step)
									3'h1:    r_d.sh = {r_q.dev, (r_q.op == OP_RD)};
									3'h2:    r_d.sh = r_q.regb;
									3'h3:    r_d.sh = r_q.datab;
									default: r_d.sh = {r_q.dev, `ISP_DIR_RD};
								endcase
							end
						end
					end
				end
			end
			default: begin
				r_d.rsp   = 1'b1;
				r_d.ready = 1'b1;
				r_d.st    = HS_IDLE;
			end
		endcase

		// Quarter-phase waveform; divider sets the fast mode rate
		if (r_d.st == HS_RUN) begin
			scl_v = (r_d.q == 2'h1) || (r_d.q == 2'h2);
			case (r_d.el)
				EL_S: sda_v = (r_d.q < 2'h2);
				EL_P: begin
					sda_v = (r_d.q >= 2'h2);
					scl_v = (r_d.q != 2'h0);
				end
				default: begin
					// Ack slot released; on a read this is the closing NACK
					if (r_d.bitn == `ISP_ACK_SLOT || r_d.rd) begin
						sda_v = 1'b1;
					end else begin
						sda_v = r_d.sh[7];
					end
				end
			endcase
		end
		r_d.scl_oe = ~scl_v;
		r_d.sda_oe = ~sda_v;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q       <= '0;
			r_q.st    <= HS_IDLE;
			r_q.op    <= OP_WR;
			r_q.el    <= EL_S;
			r_q.sda_s <= 3'h7;
			r_q.sda_f <= 1'b1;
			r_q.ready <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

endmodule

`default_nettype wire
